// ==== rtl/acmp_cfg.svh ====
// Offsets, field positions, reset values and input id limits for the compare block
`ifndef ACMP_CFG_SVH
`define ACMP_CFG_SVH
`define ACMP_CTRL_OFS 8'h00
`define ACMP_LIMIT_OFS 8'h04
`define ACMP_TIME_OFS 8'h08
`define ACMP_MODE_OFS 8'h0c
`define ACMP_RESULT_OFS 8'h10
`define ACMP_ISTAT_OFS 8'h14
`define ACMP_IMASK_OFS 8'h18
`define ACMP_CTRL_EN_BIT 7
`define ACMP_CTRL_GIEN_BIT 6
`define ACMP_CTRL_FLAG_BIT 5
`define ACMP_CTRL_ID_LSB 8
`define ACMP_CTRL_DIFF_LSB 16
`define ACMP_TIME_DIV_LSB 16
`define ACMP_TIME_RES_LSB 24
`define ACMP_TIME_RESET 32'h0300_0000
`define ACMP_MODE_LVL_BIT 0
`define ACMP_MODE_CAP_BIT 1
`define ACMP_MODE_FRACTIONAL_FORMAT_SEL_BIT 2
`define ACMP_ID_MAX 6'h2c
`define ACMP_ID_NORMAL_MAX 6'h1f
`define ACMP_IRQ_EVENT_BIT 0
`define ACMP_IRQ_SCAN_BIT 1
`endif

// ==== rtl/acmp_pkg.sv ====
// Types shared by the compare block
package acmp_pkg;
	typedef enum logic [1:0] {
		ACMP_RES_6 = 2'b00,
		ACMP_RES_8 = 2'b01,
		ACMP_RES_10 = 2'b10,
		ACMP_RES_12 = 2'b11
	} acmp_res_t;
	typedef enum logic [1:0] {
		ACMP_IDLE = 2'b00,
		ACMP_SCAN = 2'b01,
		ACMP_HOLD = 2'b10
	} acmp_scan_t;
endpackage

// ==== rtl/acmp_top.sv ====
// Converter compare, scan trigger and timing control with Avalon-MM slave
`include "acmp_cfg.svh"
module acmp_top (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Scan trigger
	input wire logic scan_trigger_source,
	input wire logic scan_done,
	output logic scan_start,
	// Conversion results
	input wire logic result_valid,
	input wire logic [5:0] result_input,
	input wire logic [11:0] conversion_result,
	input wire logic [15:0] cap_pos,
	input wire logic [15:0] cap_neg,
	output logic [11:0] masked_result,
	// Converter clock and interrupts
	output logic converter_clock_period,
	output logic comparator_irq,
	output logic irq
);
	import acmp_pkg::*;

	typedef struct packed {
		logic [7:0] ctrl_lo;
		logic [5:0] matched_input_id;
		logic [15:0] cap_sense_diff_result;
		logic [15:0] compare_low_limit;
		logic [15:0] compare_high_limit;
		logic [6:0] converter_clock_divisor;
		acmp_res_t resolution_select;
		logic [2:0] mode;
		logic [5:0] monitor_input;
		logic [1:0] istat;
		logic [1:0] imask;
		acmp_scan_t scan;
		logic trig_q;
		logic [7:0] div_cnt;
		logic tad;
		logic [11:0] masked_result;
		logic [31:0] readdata;
		logic ack;
	} acmp_state_t;

	acmp_state_t st, next_st;
	logic rst_s1, rst_s2;

	// Reset release through two flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	function automatic logic [11:0] res_mask(input acmp_res_t r,
		input logic [11:0] d);
		case (r)
			ACMP_RES_6: res_mask = {d[11:6], 6'h00};
			ACMP_RES_8: res_mask = {d[11:4], 4'h0};
			ACMP_RES_10: res_mask = {d[11:2], 2'h0};
			default: res_mask = d;
		endcase
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		end
		be_merge = r;
	endfunction

	logic en, gien, flag, hit_any, cap, lvl, fractional_format_sel, input_ok;
	logic [15:0] res16, diff;
	logic [31:0] ctrl_rd, time_rd, wv;
	logic wr_acc, rd_acc;

	always_comb begin
		next_st = st;
		en = st.ctrl_lo[`ACMP_CTRL_EN_BIT];
		gien = st.ctrl_lo[`ACMP_CTRL_GIEN_BIT];
		flag = st.ctrl_lo[`ACMP_CTRL_FLAG_BIT];
		lvl = st.mode[`ACMP_MODE_LVL_BIT];
		cap = st.mode[`ACMP_MODE_CAP_BIT];
		fractional_format_sel = st.mode[`ACMP_MODE_FRACTIONAL_FORMAT_SEL_BIT];
		ctrl_rd = {st.cap_sense_diff_result, 2'b00, st.matched_input_id,
			st.ctrl_lo};
		time_rd = {6'h00, st.resolution_select, 1'b0,
			st.converter_clock_divisor, 16'h0000};
		// Writes land at the edge that ends the wait; read data is
		// captured a cycle early so it stands when waitrequest drops
		wr_acc = write && st.ack;
		rd_acc = read && !st.ack;
		wv = 32'h0;
		next_st.ack = (read || write) && !st.ack;

		// Converter clock: high and low each last divisor control periods
		next_st.div_cnt = st.div_cnt + 8'h01;
		if (st.converter_clock_divisor == 7'h00) begin
			next_st.div_cnt = 8'h00;
			next_st.tad = 1'b0;
		end else if (st.div_cnt >= {1'b0, st.converter_clock_divisor} -
			8'h01) begin
			next_st.div_cnt = 8'h00;
			next_st.tad = !st.tad;
		end

		// Scan trigger sequencing
		next_st.trig_q = scan_trigger_source;
		case (st.scan)
			ACMP_IDLE: begin
				if (scan_trigger_source && (lvl || !st.trig_q))
					next_st.scan = ACMP_SCAN;
			end
			ACMP_SCAN: begin
				if (scan_done)
					next_st.scan = ACMP_HOLD;
			end
			ACMP_HOLD: next_st.scan = ACMP_IDLE;
			default: next_st.scan = ACMP_IDLE;
		endcase

		// Comparator, once per result of the monitored input
		res16 = {4'h0, res_mask(st.resolution_select, conversion_result)};
		diff = cap_pos - cap_neg;
		input_ok = cap ? (result_input <= `ACMP_ID_MAX)
			: (result_input <= `ACMP_ID_NORMAL_MAX);
		hit_any = (st.ctrl_lo[4] && st.compare_low_limit <= res16 &&
				res16 < st.compare_high_limit) ||
			(st.ctrl_lo[3] && res16 >= st.compare_high_limit) ||
			(st.ctrl_lo[2] && res16 < st.compare_high_limit) ||
			(st.ctrl_lo[1] && res16 >= st.compare_low_limit) ||
			(st.ctrl_lo[0] && res16 < st.compare_low_limit);
		if (result_valid)
			next_st.masked_result = res_mask(st.resolution_select,
				conversion_result);

		// Register writes
		if (wr_acc) begin
			if (address == `ACMP_CTRL_OFS) begin
				wv = be_merge(ctrl_rd, writedata, byteenable);
				next_st.ctrl_lo = {wv[7:6], flag, wv[4:0]};
			end else if (address == `ACMP_LIMIT_OFS) begin
				wv = be_merge({st.compare_high_limit, st.compare_low_limit},
					writedata, byteenable);
				next_st.compare_high_limit = wv[31:16];
				next_st.compare_low_limit = wv[15:0];
			end else if (address == `ACMP_TIME_OFS) begin
				wv = be_merge(time_rd, writedata, byteenable);
				next_st.converter_clock_divisor = wv[22:16];
				next_st.resolution_select = acmp_res_t'(wv[25:24]);
			end else if (address == `ACMP_MODE_OFS) begin
				wv = be_merge({18'h0, st.monitor_input, 5'h0, st.mode},
					writedata, byteenable);
				next_st.mode = wv[2:0];
				next_st.monitor_input = wv[13:8];
			end else if (address == `ACMP_ISTAT_OFS) begin
				next_st.istat = st.istat & ~writedata[1:0];
			end else if (address == `ACMP_IMASK_OFS) begin
				next_st.imask = writedata[1:0];
			end
		end

		// Scan completion after the clear, so a same-cycle set wins
		if (st.scan == ACMP_HOLD)
			next_st.istat[`ACMP_IRQ_SCAN_BIT] = 1'b1;

		// Reading the id field acknowledges the event
		if (read && st.ack && address == `ACMP_CTRL_OFS && byteenable[1])
			next_st.ctrl_lo[`ACMP_CTRL_FLAG_BIT] = 1'b0;
		// Disabled comparator holds the flag clear
		if (!next_st.ctrl_lo[`ACMP_CTRL_EN_BIT])
			next_st.ctrl_lo[`ACMP_CTRL_FLAG_BIT] = 1'b0;
		// Event set wins over a read clear
		if (en && next_st.ctrl_lo[`ACMP_CTRL_EN_BIT] && result_valid &&
			result_input == st.monitor_input && input_ok && hit_any) begin
			next_st.ctrl_lo[`ACMP_CTRL_FLAG_BIT] = 1'b1;
			next_st.matched_input_id = result_input;
			next_st.istat[`ACMP_IRQ_EVENT_BIT] = 1'b1;
			if (cap)
				next_st.cap_sense_diff_result = fractional_format_sel ? diff : diff;
		end

		// Read data
		if (rd_acc) begin
			if (address == `ACMP_CTRL_OFS)
				next_st.readdata = ctrl_rd;
			else if (address == `ACMP_LIMIT_OFS)
				next_st.readdata = {st.compare_high_limit, st.compare_low_limit};
			else if (address == `ACMP_TIME_OFS)
				next_st.readdata = time_rd;
			else if (address == `ACMP_MODE_OFS)
				next_st.readdata = {18'h0, st.monitor_input, 5'h0, st.mode};
			else if (address == `ACMP_RESULT_OFS)
				next_st.readdata = {20'h0, st.masked_result};
			else if (address == `ACMP_ISTAT_OFS)
				next_st.readdata = {30'h0, st.istat};
			else if (address == `ACMP_IMASK_OFS)
				next_st.readdata = {30'h0, st.imask};
			else
				next_st.readdata = 32'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_s2) begin
		if (!rst_s2) begin
			st <= '0;
			st.converter_clock_divisor <=
				7'((`ACMP_TIME_RESET >> `ACMP_TIME_DIV_LSB) & 32'h7f);
			st.resolution_select <=
				acmp_res_t'(2'((`ACMP_TIME_RESET >> `ACMP_TIME_RES_LSB) & 32'h3));
		end else begin
			st <= next_st;
		end
	end

	// One-cycle wait state on every access; answer at the following edge
	assign waitrequest = (read || write) && !st.ack;
	assign readdata = st.readdata;
	assign scan_start = (st.scan == ACMP_SCAN);
	assign masked_result = st.masked_result;
	assign converter_clock_period = st.tad;
	// Comparator interrupt gated by the global enable; irq gated by imask only
	assign comparator_irq = flag && gien;
	assign irq = |(st.istat & st.imask);

	a_irq_follows_flag: assert property (
		@(posedge clk) disable iff (!rst_s2)
		comparator_irq |-> st.ctrl_lo[`ACMP_CTRL_GIEN_BIT] &&
		st.ctrl_lo[`ACMP_CTRL_FLAG_BIT])
		else $error("irq without flag and enable");
	a_disable_clears: assert property (
		@(posedge clk) disable iff (!rst_s2)
		!st.ctrl_lo[`ACMP_CTRL_EN_BIT] |-> !st.ctrl_lo[`ACMP_CTRL_FLAG_BIT])
		else $error("flag set while disabled");
	a_id_in_range: assert property (
		@(posedge clk) disable iff (!rst_s2)
		st.matched_input_id <= `ACMP_ID_MAX)
		else $error("reserved id stored");
	a_edge_single: assert property (
		@(posedge clk) disable iff (!rst_s2)
		(st.scan == ACMP_IDLE && !lvl && st.trig_q) |=> st.scan == ACMP_IDLE)
		else $error("edge mode rescanned on a steady trigger");
	a_level_restart: assert property (
		@(posedge clk) disable iff (!rst_s2)
		(st.scan == ACMP_IDLE && lvl && scan_trigger_source)
		|=> st.scan == ACMP_SCAN)
		else $error("level trigger did not rescan");
	a_flag_sticky: assert property (
		@(posedge clk) disable iff (!rst_s2)
		(flag && en && !(read && st.ack) && !(write && st.ack))
		|=> st.ctrl_lo[`ACMP_CTRL_FLAG_BIT])
		else $error("flag lost");
	a_between_hit: assert property (
		@(posedge clk) disable iff (!rst_s2)
		(en && st.ctrl_lo[4] && result_valid && !(write && st.ack) &&
		result_input == st.monitor_input && input_ok &&
		st.compare_low_limit <= res16 && res16 < st.compare_high_limit)
		|=> st.ctrl_lo[`ACMP_CTRL_FLAG_BIT])
		else $error("between hit missed");
	a_normal_range: assert property (
		@(posedge clk) disable iff (!rst_s2)
		(!cap && result_valid && result_input > `ACMP_ID_NORMAL_MAX)
		|=> $stable(st.matched_input_id))
		else $error("high input matched in normal mode");
	// Status bits only fall on a one written to them
	a_istat_sticky: assert property (
		@(posedge clk) disable iff (!rst_s2)
		(st.istat[`ACMP_IRQ_EVENT_BIT] &&
		!(write && st.ack && address == `ACMP_ISTAT_OFS))
		|=> st.istat[`ACMP_IRQ_EVENT_BIT])
		else $error("status bit lost");
	a_res_zero: assert property (
		@(posedge clk) disable iff (!rst_s2)
		(result_valid && st.resolution_select == ACMP_RES_6)
		|=> masked_result[5:0] == 6'h00)
		else $error("low bits not zero");
	a_ack_one: assert property (
		@(posedge clk) disable iff (!rst_s2)
		(read && waitrequest) |=> !waitrequest)
		else $error("wait too long");
	a_div_period: assert property (
		@(posedge clk) disable iff (!rst_s2)
		(st.converter_clock_divisor == 7'h01 &&
		$stable(st.converter_clock_divisor))
		|-> $changed(st.tad) || st.div_cnt != 8'h00)
		else $error("divider stalled");
endmodule

// ==== testbench/acmp_conv_model.sv ====
// Converter model: answers scans and delivers conversion results
module acmp_conv_model (
	// Clock
	input wire logic clk,
	// Scan handshake
	input wire logic scan_start,
	output logic scan_done,
	// Results
	output logic result_valid,
	output logic [5:0] result_input,
	output logic [11:0] conversion_result,
	output logic [15:0] cap_pos,
	output logic [15:0] cap_neg
);
	timeunit 1ns;
	timeprecision 1ns;
	int scans = 0;
	int lat = 2;
	int cnt = 0;
	initial begin
		scan_done = 0;
		result_valid = 0;
		result_input = 0;
		conversion_result = 0;
		cap_pos = 0;
		cap_neg = 0;
	end
	always @(posedge clk) begin
		scan_done <= 0;
		if (!scan_start || scan_done) cnt <= 0;
		else if (cnt == lat) begin
			scan_done <= 1; // One pulse ends each scan
			scans <= scans + 1;
		end
		else cnt <= cnt + 1;
	end
	// Inverted values once valid drops, so stale data is never trusted
	task automatic send(input logic [5:0] id, input logic [11:0] v,
		input logic [15:0] p, input logic [15:0] n);
		@(posedge clk);
		result_valid <= 1;
		result_input <= id;
		conversion_result <= v;
		cap_pos <= p;
		cap_neg <= n;
		@(posedge clk);
		result_valid <= 0;
		result_input <= ~id;
		conversion_result <= ~v;
		cap_pos <= ~p;
		cap_neg <= ~n;
	endtask
endmodule

// ==== testbench/tb_top.sv ====
// Testbench for the compare, scan trigger and timing block
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic nrst = 0;
	logic [7:0] address = 0;
	logic read = 0;
	logic write = 0;
	logic [31:0] writedata = 0;
	logic scan_trigger_source = 0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata, q;
	logic waitrequest, scan_done, scan_start, result_valid;
	logic [5:0] result_input;
	logic [11:0] conversion_result, masked_result;
	logic [15:0] cap_pos, cap_neg;
	logic converter_clock_period, comparator_irq, irq;
	int bad_count = 0;
	int cmp_count = 0;
	always #25 clk = ~clk;
	acmp_top u_dut (.clk, .nrst, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .scan_trigger_source,
		.scan_done, .scan_start, .result_valid, .result_input,
		.conversion_result, .cap_pos, .cap_neg, .masked_result,
		.converter_clock_period, .comparator_irq, .irq);
	acmp_conv_model u_conv (.clk, .scan_start, .scan_done, .result_valid,
		.result_input, .conversion_result, .cap_pos, .cap_neg);
	task automatic chk(input string s, input logic [31:0] g,
		input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	// Request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		address <= a;
		read <= !w;
		write <= w;
		writedata <= d;
		do
			@(posedge clk);
		while (waitrequest !== 1'b0);
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(a, 0, 0, r);
	endtask
	task automatic t_cmp;
		wr(8'h04, 32'h0200_0100);
		wr(8'h0c, 32'h0000_0500);
		wr(8'h18, 32'h0);
		wr(8'h00, 32'h0000_00d0);
		u_conv.send(6'h05, 12'h200, 16'h0, 16'h0);
		u_conv.send(6'h04, 12'h100, 16'h0, 16'h0);
		@(negedge clk);
		chk("no event", comparator_irq, 0);
		u_conv.send(6'h05, 12'h100, 16'h0, 16'h0);
		repeat (5) @(negedge clk);
		chk("event", {comparator_irq, irq}, 2'b10);
		wr(8'h18, 32'h1);
		@(negedge clk);
		chk("unmasked", irq, 1);
		@(posedge clk);
		byteenable <= 4'h1;
		rd(8'h00, q);
		byteenable <= 4'hf;
		@(negedge clk);
		chk("low lane read", comparator_irq, 1);
		rd(8'h00, q);
		chk("ctrl", q, 32'h0000_05f0);
		@(negedge clk);
		chk("ack", comparator_irq, 0);
		wr(8'h14, 32'h1);
		@(negedge clk);
		chk("w1c", irq, 0);
		$display("compare done");
	endtask
	task automatic t_dis;
		wr(8'h00, 32'h0000_0090);
		u_conv.send(6'h05, 12'h180, 16'h0, 16'h0);
		@(negedge clk);
		chk("gien off", {comparator_irq, irq}, 2'b01);
		wr(8'h00, 32'h0000_0050);
		u_conv.send(6'h05, 12'h180, 16'h0, 16'h0);
		wr(8'h00, 32'h0000_00d0);
		@(negedge clk);
		chk("disabled", comparator_irq, 0);
		wr(8'h14, 32'h1);
		$display("disable done");
	endtask
	task automatic t_cap;
		wr(8'h0c, 32'h0000_2100);
		u_conv.send(6'h21, 12'h180, 16'h0190, 16'h0010);
		@(negedge clk);
		chk("normal hi id", comparator_irq, 0);
		wr(8'h0c, 32'h0000_2102);
		u_conv.send(6'h21, 12'h180, 16'h0190, 16'h0010);
		@(negedge clk);
		chk("cap event", comparator_irq, 1);
		rd(8'h00, q);
		chk("cap ctrl", q, 32'h0180_21f0);
		wr(8'h14, 32'h1);
		$display("cap done");
	endtask
	task automatic t_res;
		for (int r = 0; r < 4; r++) begin
			wr(8'h08, r << 24);
			u_conv.send(6'h00, 12'hfff, 16'h0, 16'h0);
			@(negedge clk);
			chk("res", masked_result, 12'(12'hfff << (6 - 2 * r)));
		end
		$display("resolution done");
	endtask
	task automatic t_div;
		int n;
		for (int d = 1; d < 4; d += 2) begin
			wr(8'h08, 32'h0300_0000 | (d << 16));
			repeat (2) @(posedge converter_clock_period);
			n = 0;
			@(negedge clk);
			while (converter_clock_period === 1'b1) begin
				@(negedge clk);
				n++;
			end
			while (converter_clock_period === 1'b0 && n < 600) begin
				@(negedge clk);
				n++;
			end
			chk("period", n, 2 * d);
		end
		$display("divisor done");
	endtask
	task automatic t_scan(input logic lvl);
		wr(8'h0c, {31'h0, lvl});
		wr(8'h14, 32'h3);
		u_conv.scans = 0;
		u_conv.lat = lvl ? 8 : 2;
		scan_trigger_source <= 1;
		repeat (40) @(posedge clk);
		scan_trigger_source <= 0;
		repeat (20) @(negedge clk);
		if (lvl) chk("level", u_conv.scans > 1, 1);
		else chk("edge", u_conv.scans, 1);
		chk("idle", scan_start, 0);
		rd(8'h14, q);
		chk("scan stat", q[1], 1);
		$display("scan done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_sim;
	end
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1;
		repeat (3) @(posedge clk);
		rd(8'h08, q);
		chk("time rst", q, 32'h0300_0000);
		rd(8'h00, q);
		chk("ctrl rst", q, 0);
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40, q);
		chk("unmapped", q, 0);
		$display("regs done");
		t_cmp;
		t_dis;
		t_cap;
		t_res;
		t_div;
		t_scan(0);
		t_scan(1);
		end_sim;
	end
endmodule
